// >>> core/acm_channel_mux.sv
// converter channel decode, synthesized results and reference select
`timescale 1ns/1ns
`default_nettype none

module acm_channel_mux
  import acm_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = ACM_LEGACY_CYCLES
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        rst_b_i,
  // processor side
  input  wire logic        start_i,
  input  wire logic [3:0]  adc_channel_select_i,
  input  wire logic        res12_i,
  input  wire logic [1:0]  ref_sel_i,
  input  wire logic [12:0] ext_ref_mv_i,
  output logic             busy_o,
  output logic             done_o,
  output acm_result_s      result_o,
  // converter side
  output logic             conv_start_o,
  output logic [2:0]       conv_chan_o,
  input  wire logic        conv_done_i,
  input  wire logic [11:0] conv_data_i,
  // board reference select
  output acm_refsel_s      refsel_o
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_analog(input logic [3:0] ch);
    return ch <= ACM_CH_SUPPLY;
  endfunction

  function automatic logic [12:0] ref_mv(input logic [1:0] sel, input logic [12:0] ext);
    unique case (sel)
      ACM_REF_BANDGAP: ref_mv = {2'h0, ACM_BANDGAP_MV};
      ACM_REF_EXT:     ref_mv = ext;
      default:         ref_mv = ACM_SUPPLY_MV;
    endcase
  endfunction

  acm_state_e  state_q;
  logic [3:0]  chan_q;
  logic        res12_q;
  logic [13:0] elapsed_q;
  logic [12:0] div_q;
  logic [22:0] num_q;
  logic [23:0] rem_q;
  logic [22:0] quo_q;
  logic [4:0]  step_q;
  logic [11:0] value_q;
  logic        unsup_q;
  logic [23:0] rem_shift;
  logic [11:0] fs;

  assign fs        = res12_q ? ACM_FS_12 : ACM_FS_10;
  assign rem_shift = {rem_q[22:0], num_q[22]};

  // ----------------------------------------------------------------
  // sequence control
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      state_q      <= ACM_S_IDLE;
      chan_q       <= 4'h0;
      res12_q      <= 1'b0;
      conv_start_o <= 1'b0;
      conv_chan_o  <= 3'h0;
      busy_o       <= 1'b0;
      unsup_q      <= 1'b0;
    end else begin
      conv_start_o <= 1'b0;
      unique case (state_q)
        ACM_S_IDLE: begin
          if (start_i) begin
            chan_q  <= adc_channel_select_i;
            res12_q <= res12_i;
            busy_o  <= 1'b1;
            unsup_q <= 1'b0;
            if (is_analog(adc_channel_select_i)) begin
              conv_start_o <= 1'b1;
              conv_chan_o  <= adc_channel_select_i[2:0];
              state_q      <= ACM_S_CONV;
            end else if (adc_channel_select_i == ACM_CH_BANDGAP) begin
              state_q <= ACM_S_CALC;
            end else begin
              // ground and every code without a path finish with zero
              unsup_q <= adc_channel_select_i != ACM_CH_GROUND;
              state_q <= ACM_S_HOLD;
            end
          end
        end
        ACM_S_CONV: begin
          if (conv_done_i) begin
            state_q <= ACM_S_HOLD;
          end
        end
        ACM_S_CALC: begin
          if (step_q == 5'(ACM_DIV_STEPS - 1)) begin
            state_q <= ACM_S_HOLD;
          end
        end
        ACM_S_HOLD: begin
          if (elapsed_q >= 14'(CONV_CYCLES)) begin
            state_q <= ACM_S_IDLE;
            busy_o  <= 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // legacy-rate timer, started with every request
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      elapsed_q <= 14'h0;
    end else if (state_q == ACM_S_IDLE) begin
      elapsed_q <= 14'h1;
    end else if (elapsed_q != 14'h3fff) begin
      elapsed_q <= elapsed_q + 14'h1;
    end
  end

  // ----------------------------------------------------------------
  // bandgap ratio: 1100 * full scale / reference mV
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      div_q  <= 13'h0;
      num_q  <= 23'h0;
      rem_q  <= 24'h0;
      quo_q  <= 23'h0;
      step_q <= 5'h0;
    end else if (state_q == ACM_S_IDLE) begin
      div_q  <= ref_mv(ref_sel_i, ext_ref_mv_i);
      num_q  <= {12'h0, ACM_BANDGAP_MV} * {11'h0, (res12_i ? ACM_FS_12 : ACM_FS_10)};
      rem_q  <= 24'h0;
      quo_q  <= 23'h0;
      step_q <= 5'h0;
    end else if (state_q == ACM_S_CALC) begin
      num_q  <= {num_q[21:0], 1'b0};
      step_q <= step_q + 5'h1;
      if (div_q != 13'h0 && rem_shift >= {11'h0, div_q}) begin
        rem_q <= rem_shift - {11'h0, div_q};
        quo_q <= {quo_q[21:0], 1'b1};
      end else begin
        rem_q <= rem_shift;
        quo_q <= {quo_q[21:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // result capture and completion
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      value_q  <= 12'h0;
      result_o <= '0;
      done_o   <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (state_q == ACM_S_IDLE && start_i) begin
        value_q <= 12'h0;
      end else if (state_q == ACM_S_CONV && conv_done_i) begin
        value_q <= res12_q ? conv_data_i : {2'h0, conv_data_i[11:2]};
      end else if (state_q == ACM_S_CALC && step_q == 5'(ACM_DIV_STEPS - 1)) begin
        // last quotient bit folded in here; zero divisor saturates
        if (div_q == 13'h0 || {quo_q[21:0], (rem_shift >= {11'h0, div_q})} > {11'h0, fs}) begin
          value_q <= fs;
        end else begin
          value_q <= {quo_q[10:0], (rem_shift >= {11'h0, div_q})};
        end
      end
      if (state_q == ACM_S_HOLD && elapsed_q >= 14'(CONV_CYCLES)) begin
        result_o.value       <= value_q;
        result_o.unsupported <= unsup_q;
        done_o               <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // reference choice registered onto board select lines, one cycle later
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      refsel_o <= '{supply: 1'b1, bandgap: 1'b0, external: 1'b0};
    end else begin
      refsel_o.supply   <= ref_sel_i != ACM_REF_BANDGAP && ref_sel_i != ACM_REF_EXT;
      refsel_o.bandgap  <= ref_sel_i == ACM_REF_BANDGAP;
      refsel_o.external <= ref_sel_i == ACM_REF_EXT;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_ext_route: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    state_q == ACM_S_IDLE && start_i && adc_channel_select_i <= ACM_CH_LAST_EXT
    |=> conv_start_o && conv_chan_o == $past(adc_channel_select_i[2:0]))
    else $error("external input not routed");

  a_supply_route: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    state_q == ACM_S_IDLE && start_i && adc_channel_select_i == ACM_CH_SUPPLY
    |=> conv_start_o && conv_chan_o == 3'h6)
    else $error("supply divider not routed");

  a_unsup_nopath: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    state_q == ACM_S_IDLE && start_i
    && (adc_channel_select_i == ACM_CH_CH7 || adc_channel_select_i == ACM_CH_TEMP)
    |=> !conv_start_o && state_q == ACM_S_HOLD)
    else $error("unsupported code started a conversion");

  a_bg_noconv: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    state_q == ACM_S_IDLE && start_i && adc_channel_select_i == ACM_CH_BANDGAP
    |=> !conv_start_o ##0 (state_q == ACM_S_CALC) [*8])
    else $error("bandgap code did not compute");

  a_gnd_zero: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    done_o && chan_q == ACM_CH_GROUND |-> result_o.value == 12'h0 && !result_o.unsupported)
    else $error("ground code gave nonzero");

  a_res10_width: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    done_o && !res12_q |-> result_o.value[11:10] == 2'h0)
    else $error("10-bit result too wide");

  a_res12_bg: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    done_o && res12_q && chan_q == ACM_CH_BANDGAP && div_q == {2'h0, ACM_BANDGAP_MV}
    |-> result_o.value == ACM_FS_12)
    else $error("12-bit bandgap ratio wrong");

  a_ref_select: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    ##1 refsel_o.external == ($past(ref_sel_i) == ACM_REF_EXT)
    && refsel_o.bandgap == ($past(ref_sel_i) == ACM_REF_BANDGAP)
    && $onehot({refsel_o.supply, refsel_o.bandgap, refsel_o.external}))
    else $error("reference select mismatch");

  a_min_time: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    done_o |-> !busy_o && $past(elapsed_q) >= 14'(CONV_CYCLES) ##1 !done_o)
    else $error("completion too early or stretched");

  c_ext_conv: cover property (@(posedge clock_i) disable iff (!rst_b_i)
    conv_start_o ##[1:1000] done_o);
  c_bandgap: cover property (@(posedge clock_i) disable iff (!rst_b_i)
    done_o && chan_q == ACM_CH_BANDGAP);
  c_ground: cover property (@(posedge clock_i) disable iff (!rst_b_i)
    done_o && chan_q == ACM_CH_GROUND);
  c_unsup: cover property (@(posedge clock_i) disable iff (!rst_b_i)
    done_o && result_o.unsupported);

endmodule

`default_nettype wire

// >>> core/acm_pkg.sv
// constants and carrier types for the converter channel control
package acm_pkg;

  // ----------------------------------------------------------------
  // channel codes
  // ----------------------------------------------------------------
  localparam logic [3:0] ACM_CH_LAST_EXT = 4'h5;
  localparam logic [3:0] ACM_CH_SUPPLY   = 4'h6;
  localparam logic [3:0] ACM_CH_CH7      = 4'h7;
  localparam logic [3:0] ACM_CH_TEMP     = 4'h8;
  localparam logic [3:0] ACM_CH_BANDGAP  = 4'he;
  localparam logic [3:0] ACM_CH_GROUND   = 4'hf;

  // ----------------------------------------------------------------
  // result widths and scaling
  // ----------------------------------------------------------------
  localparam logic [11:0] ACM_FS_10      = 12'h3ff;
  localparam logic [11:0] ACM_FS_12      = 12'hfff;
  localparam logic [10:0] ACM_BANDGAP_MV = 11'h44c;  // 1100 mV
  localparam logic [12:0] ACM_SUPPLY_MV  = 13'h1388; // 5000 mV
  localparam int          ACM_DIV_STEPS  = 23;

  // ----------------------------------------------------------------
  // reference choice codes
  // ----------------------------------------------------------------
  localparam logic [1:0] ACM_REF_SUPPLY  = 2'h0;
  localparam logic [1:0] ACM_REF_BANDGAP = 2'h1;
  localparam logic [1:0] ACM_REF_EXT     = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int ACM_CLK_NS         = 8;
  localparam int ACM_LEGACY_CONV_NS = 104000; // 13 clocks at 125 kHz
  localparam int ACM_LEGACY_CYCLES  = (ACM_LEGACY_CONV_NS + ACM_CLK_NS - 1) / ACM_CLK_NS;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ACM_S_IDLE = 4'b0001,
    ACM_S_CONV = 4'b0010,
    ACM_S_CALC = 4'b0100,
    ACM_S_HOLD = 4'b1000
  } acm_state_e;

  typedef struct packed {
    logic        unsupported;
    logic [11:0] value;
  } acm_result_s;

  typedef struct packed {
    logic supply;
    logic bandgap;
    logic external;
  } acm_refsel_s;

endpackage

// >>> dv/acm_conv_model.sv
// behavioural converter standing on the far side of the channel control
`timescale 1ns/1ns
`default_nettype none

module acm_conv_model (
  // clock
  input  wire logic        clock_i,
  // request from the channel control
  input  wire logic        conv_start_i,
  input  wire logic [2:0]  conv_chan_i,
  // stimulus from the bench
  input  wire logic [11:0] sample_i,
  input  wire logic [7:0]  lat_i,
  // answer and bookkeeping
  output logic             conv_done_o,
  output logic [11:0]      conv_data_o,
  output logic [2:0]       chan_o,
  output var int           starts_o
);
  int   cnt;
  logic busy;

  initial begin
    conv_done_o = 1'b0;
    conv_data_o = 12'h0;
    chan_o      = 3'h0;
    starts_o    = 0;
    busy        = 1'b0;
    cnt         = 0;
  end

  // data only holds during the done cycle, otherwise it toggles
  always @(posedge clock_i) begin
    conv_done_o <= 1'b0;
    conv_data_o <= ~conv_data_o;
    if (conv_start_i) begin
      busy     <= 1'b1;
      cnt      <= lat_i;
      chan_o   <= conv_chan_i;
      starts_o <= starts_o + 1;
    end else if (busy && cnt == 0) begin
      busy        <= 1'b0;
      conv_done_o <= 1'b1;
      conv_data_o <= sample_i;
    end else if (busy) begin
      cnt <= cnt - 1;
    end
  end
endmodule

`default_nettype wire

// >>> dv/acm_channel_mux_test.sv
// self-checking bench for the converter channel control
`timescale 1ns/1ns
`default_nettype none

module acm_channel_mux_test
  import acm_pkg::*;
;
  localparam int CC = 40;
  logic        clock_i, rst_b_i, start_i, res12_i, conv_start, conv_done, busy_o, done_o;
  logic [3:0]  sel_i;
  logic [1:0]  ref_sel_i;
  logic [12:0] ext_i;
  logic [11:0] conv_data, sample;
  logic [2:0]  conv_chan, m_chan;
  logic [7:0]  lat;
  acm_result_s result_o;
  acm_refsel_s refsel_o;
  int          starts, fails, samples_checked, ref_n;
  int          cyc = 0;
  logic [12:0] exp_q[$];

  acm_channel_mux #(.CONV_CYCLES(CC)) uut (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .start_i(start_i), .adc_channel_select_i(sel_i), .res12_i(res12_i), .ref_sel_i(ref_sel_i),
    .ext_ref_mv_i(ext_i), .busy_o(busy_o), .done_o(done_o), .result_o(result_o),
    .conv_start_o(conv_start), .conv_chan_o(conv_chan), .conv_done_i(conv_done),
    .conv_data_i(conv_data), .refsel_o(refsel_o));

  acm_conv_model model (.clock_i(clock_i), .conv_start_i(conv_start), .conv_chan_i(conv_chan),
    .sample_i(sample), .lat_i(lat), .conv_done_o(conv_done), .conv_data_o(conv_data),
    .chan_o(m_chan), .starts_o(starts));

  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  always @(posedge clock_i) cyc <= cyc + 1;

  // ------------------------------------------------------------
  // reference model and checking
  // ------------------------------------------------------------
  function automatic logic [12:0] model_res(int code, int r12, int rs, int ext, int smp);
    int fs, rv, q;
    fs = r12 ? 4095 : 1023;
    rv = (rs == 1) ? 1100 : (rs == 2) ? ext : 5000;
    q = (rv == 0) ? fs : 1100 * fs / rv;
    if (code <= 6) return {1'b0, 12'(r12 ? smp : smp / 4)};
    if (code == 14) return {1'b0, 12'((q > fs) ? fs : q)};
    if (code == 15) return 13'h0;
    return 13'h1000;
  endfunction

  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (fails == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(negedge clock_i) begin
    if (done_o === 1'b1) check(13'(result_o), exp_q.pop_front());
  end

  // one request; start is held a second cycle with another code to be ignored
  task automatic run(input logic [3:0] code, input logic r12, input logic [1:0] rs,
                     input logic [12:0] ext, input logic [11:0] smp, input logic [7:0] l);
    int t0, s0, n;
    @(negedge clock_i);
    res12_i = r12;
    ref_sel_i = rs;
    ext_i = ext;
    sample = smp;
    lat = l;
    sel_i = code;
    @(negedge clock_i);
    check(13'(refsel_o), (rs == 2'h1) ? 13'h2 : (rs == 2'h2) ? 13'h1 : 13'h4);
    exp_q.push_back(model_res(code, r12, rs, ext, smp));
    t0 = cyc;
    s0 = starts;
    start_i = 1'b1;
    @(negedge clock_i);
    sel_i = ~code;
    @(negedge clock_i);
    start_i = 1'b0;
    for (n = 0; n < 2000 && done_o !== 1'b1; n++) @(negedge clock_i);
    check(13'(done_o === 1'b1), 13'h1);
    n = cyc - t0;
    check(13'(n >= CC + 1), 13'h1);
    if (l < 8'd20) begin
      if (ref_n < 0) ref_n = n;
      check(13'(n), 13'(ref_n));
    end
    check(13'(starts - s0), 13'(code <= 4'h6));
    if (code <= 4'h6) check(13'(m_chan), 13'(code));
    @(negedge clock_i);
    check({11'h0, done_o, busy_o}, 13'h0);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(99));
    rst_b_i = 1'b0;
    start_i = 1'b0;
    sel_i = 4'h0;
    res12_i = 1'b0;
    ref_sel_i = 2'h0;
    ext_i = 13'h0;
    sample = 12'h0;
    lat = 8'h0;
    ref_n = -1;
    repeat (8) @(negedge clock_i);
    rst_b_i = 1'b1;
    check(13'({refsel_o, busy_o, done_o, conv_start}), 13'h20);
    check(13'(result_o), 13'h0);
    for (int c = 0; c < 16; c++) begin
      run(4'(c), 1'($urandom), 2'($urandom), 13'($urandom_range(0, 6000)), 12'($urandom),
          8'($urandom_range(0, 8)));
    end
    for (int i = 0; i < 8; i++) run(4'he, 1'(i), 2'(i / 2), 13'(i * 700), 12'h0, 8'h0);
    run(4'he, 1'b1, 2'h2, 13'h0, 12'h0, 8'h0);
    run(4'h2, 1'b1, 2'h0, 13'h0, 12'habc, 8'd60);
    repeat (16) begin
      run(4'($urandom), 1'($urandom), 2'($urandom), 13'($urandom_range(0, 6000)),
          12'($urandom), 8'($urandom_range(0, 8)));
    end
    end_of_test();
  end

  initial begin
    // 42 requests of under 100 cycles each, with ample margin
    #200000;
    fails++;
    end_of_test();
  end
endmodule

`default_nettype wire
